// ---- include/dma_chan_cfg.svh ----
// Offsets, field positions, reset values and limits of the channel registers
`ifndef DMA_CHAN_CFG_SVH
`define DMA_CHAN_CFG_SVH
`define DMA_NUM_CHAN 8
`define DMA_ADDR_W 8
`define DMA_OFS_PAD_BASE 8'h00
`define DMA_OFS_CNT_BASE 8'h10
`define DMA_OFS_CTRL_BASE 8'h20
`define DMA_OFS_COLL 8'h30
`define DMA_OFS_IRQ_MASK 8'h31
`define DMA_OFS_DONE 8'h32
`define DMA_CNT_W 10
`define DMA_CTRL_ON_BIT 15
`define DMA_CTRL_DIR_BIT 13
`define DMA_RESET_VAL 16'h0000
`endif

// ---- include/dma_chan_pkg.sv ----
// Types shared by the channel register block and its helpers
package dma_chan_pkg;
    typedef logic [15:0] word_t;
    typedef logic [7:0] chan_vec_t;
    typedef struct packed {
        logic [7:0] addr;
        word_t wdata;
        logic wr;
        logic rd;
    } bus_req_t;
    typedef struct packed {
        chan_vec_t periph;
        chan_vec_t ram;
    } coll_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b11
    } eng_state_t;
endpackage : dma_chan_pkg

// ---- design/dma_coll_detect.sv ----
// Combinational detector of DMA versus CPU write collisions per channel
module dma_coll_detect #(
    parameter int NCH = 8
) (
    input wire logic [NCH-1:0] dma_wr_in,
    input wire logic [NCH-1:0] dma_to_ram_in,
    input wire logic [NCH*16-1:0] dma_addr_in,
    input wire logic cpu_ram_wr_in,
    input wire logic [15:0] cpu_ram_addr_in,
    input wire logic cpu_per_wr_in,
    input wire logic [15:0] cpu_per_addr_in,
    output logic [NCH-1:0] ram_hit_out,
    output logic [NCH-1:0] per_hit_out
);
    // Same-location writes in one cycle collide; the DMA side decides target
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ram_hit_out[i] = dma_wr_in[i] && dma_to_ram_in[i] && cpu_ram_wr_in
                && (dma_addr_in[i*16 +: 16] == cpu_ram_addr_in);
            per_hit_out[i] = dma_wr_in[i] && !dma_to_ram_in[i] && cpu_per_wr_in
                && (dma_addr_in[i*16 +: 16] == cpu_per_addr_in);
        end
    end
endmodule : dma_coll_detect

// ---- design/dma_block_counter.sv ----
// Per-channel transfer counter that ends a block after count plus one moves
module dma_block_counter #(
    parameter int CW = 10
) (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic step_in,
    input wire logic [CW-1:0] count_in,
    output logic busy_out,
    output logic last_out,
    output logic done_out
);
    typedef struct packed {
        dma_chan_pkg::eng_state_t st;
        logic [CW-1:0] left;
        logic done;
    } cnt_state_t;
    cnt_state_t s_r;
    cnt_state_t s_nxt;

    // Remaining moves reach zero on the last one of the block
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        unique case (s_r.st)
            dma_chan_pkg::ST_IDLE: begin
                if (start_in) begin
                    s_nxt.st = dma_chan_pkg::ST_RUN;
                    s_nxt.left = count_in;
                end
            end
            dma_chan_pkg::ST_RUN: begin
                if (abort_in) begin
                    s_nxt.st = dma_chan_pkg::ST_IDLE;
                end else if (step_in) begin
                    if (s_r.left == '0) begin
                        s_nxt.st = dma_chan_pkg::ST_DONE;
                        s_nxt.done = 1'b1;
                    end else begin
                        s_nxt.left = s_r.left - 1'b1;
                    end
                end
            end
            dma_chan_pkg::ST_DONE: begin
                s_nxt.st = dma_chan_pkg::ST_IDLE;
            end
            default: begin
                s_nxt.st = dma_chan_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy_out = (s_r.st == dma_chan_pkg::ST_RUN);
    assign last_out = busy_out && (s_r.left == '0);
    assign done_out = s_r.done;
endmodule : dma_block_counter

// ---- design/dma_chan_regs.sv ----
// Channel address, count, control and collision status registers with engine
//
// Summary of operation
// - Each channel has a 16-bit read/write peripheral address, reset zero.
// - Each channel has a 10-bit read/write count field, reset zero.
// - Count bits above the field read zero and ignore writes.
// - One block moves exactly count plus one items.
// - Status upper byte holds peripheral collision flags, channel 7 on top.
// - Status lower byte holds RAM collision flags, channel 7 on top.
// - Flags read one after a collision, reset zero, software only clears.
// - A channel runs only while its on bit is set.
// - Direction bit picks peripheral as source or as destination.
`include "dma_chan_cfg.svh"
module dma_chan_regs #(
    parameter int NCH = `DMA_NUM_CHAN,
    parameter int CW = `DMA_CNT_W
) (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] XFER_REQ_IN,
    input wire logic CPU_RAM_WR_IN,
    input wire logic [15:0] CPU_RAM_ADDR_IN,
    input wire logic CPU_PER_WR_IN,
    input wire logic [15:0] CPU_PER_ADDR_IN,
    output logic [15:0] RDATA_OUT,
    output logic [7:0] XFER_ACK_OUT,
    output logic [7:0] DIR_TO_PER_OUT,
    output logic [127:0] PER_ADDR_OUT,
    output logic [7:0] BLOCK_DONE_OUT,
    output logic IRQ_OUT
);
    initial begin
        if (NCH != 8 || CW < 1 || CW > 16) begin
            $error("dma_chan_regs: NCH must be 8, CW 1..16");
        end
    end

    typedef struct packed {
        logic [NCH-1:0][15:0] pad;
        logic [NCH-1:0][CW-1:0] cnt;
        logic [NCH-1:0][15:0] ctrl;
        dma_chan_pkg::coll_t coll;
        dma_chan_pkg::chan_vec_t done;
        logic [15:0] mask;
        logic [15:0] rdata;
        dma_chan_pkg::chan_vec_t ack;
        dma_chan_pkg::chan_vec_t done_p;
        logic irq;
    } regs_state_t;
    regs_state_t s_r;
    regs_state_t s_nxt;

    dma_chan_pkg::bus_req_t req;
    dma_chan_pkg::chan_vec_t on_v;
    dma_chan_pkg::chan_vec_t on_q;
    dma_chan_pkg::chan_vec_t to_ram_v;
    dma_chan_pkg::chan_vec_t busy_v;
    dma_chan_pkg::chan_vec_t last_v;
    dma_chan_pkg::chan_vec_t done_v;
    dma_chan_pkg::chan_vec_t step_v;
    dma_chan_pkg::chan_vec_t start_v;
    dma_chan_pkg::chan_vec_t ram_hit;
    dma_chan_pkg::chan_vec_t per_hit;
    logic [NCH*16-1:0] pad_flat;
    logic [7:0] xreq_s1;
    logic [7:0] xreq_s2;

    // Which register window an address falls in
    function automatic logic in_win(input logic [7:0] a, input logic [7:0] b);
        in_win = (a >= b) && (a < b + 8'h08);
    endfunction : in_win

    assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

    // Transfer requests come from other logic; synchronise them regardless
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            xreq_s1 <= 8'h00;
            xreq_s2 <= 8'h00;
            on_q <= 8'h00;
        end else begin
            xreq_s1 <= XFER_REQ_IN;
            xreq_s2 <= xreq_s1;
            on_q <= on_v;
        end
    end

    // Per-channel views of the control words
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            on_v[i] = s_r.ctrl[i][`DMA_CTRL_ON_BIT];
            to_ram_v[i] = !s_r.ctrl[i][`DMA_CTRL_DIR_BIT];
            pad_flat[i*16 +: 16] = s_r.pad[i];
            start_v[i] = on_v[i] && !on_q[i];
            step_v[i] = busy_v[i] && xreq_s2[i] && on_v[i];
        end
    end

    // Block length counters, one per channel
    for (genvar g = 0; g < NCH; g++) begin : g_cnt
        dma_block_counter #(.CW(CW)) u_cnt (
            .CLK_IN(CLK_IN),
            .RESET_N_IN(RESET_N_IN),
            .start_in(start_v[g]),
            .abort_in(!on_v[g]),
            .step_in(step_v[g]),
            .count_in(s_r.cnt[g]),
            .busy_out(busy_v[g]),
            .last_out(last_v[g]),
            .done_out(done_v[g])
        );
    end

    dma_coll_detect #(.NCH(NCH)) u_coll (
        .dma_wr_in(step_v),
        .dma_to_ram_in(to_ram_v),
        .dma_addr_in(pad_flat),
        .cpu_ram_wr_in(CPU_RAM_WR_IN),
        .cpu_ram_addr_in(CPU_RAM_ADDR_IN),
        .cpu_per_wr_in(CPU_PER_WR_IN),
        .cpu_per_addr_in(CPU_PER_ADDR_IN),
        .ram_hit_out(ram_hit),
        .per_hit_out(per_hit)
    );

    // Register writes, flag updates and read mux
    always_comb begin
        logic [2:0] idx;
        logic [15:0] rd;
        s_nxt = s_r;
        idx = req.addr[2:0];
        rd = 16'h0000;
        // Writes while a channel is on are accepted but unsafe
        if (req.wr) begin
            if (in_win(req.addr, `DMA_OFS_PAD_BASE)) begin
                s_nxt.pad[idx] = req.wdata;
            end else if (in_win(req.addr, `DMA_OFS_CNT_BASE)) begin
                s_nxt.cnt[idx] = req.wdata[CW-1:0];
            end else if (in_win(req.addr, `DMA_OFS_CTRL_BASE)) begin
                s_nxt.ctrl[idx] = req.wdata;
            end else if (req.addr == `DMA_OFS_COLL) begin
                s_nxt.coll = s_r.coll & ~req.wdata;
            end else if (req.addr == `DMA_OFS_IRQ_MASK) begin
                s_nxt.mask = req.wdata;
            end else if (req.addr == `DMA_OFS_DONE) begin
                s_nxt.done = s_r.done & ~req.wdata[7:0];
            end
        end
        // Hardware set wins over a same-cycle software clear
        s_nxt.coll.periph = s_nxt.coll.periph | per_hit;
        s_nxt.coll.ram = s_nxt.coll.ram | ram_hit;
        s_nxt.done = s_nxt.done | done_v;
        if (req.rd) begin
            if (in_win(req.addr, `DMA_OFS_PAD_BASE)) begin
                rd = s_r.pad[idx];
            end else if (in_win(req.addr, `DMA_OFS_CNT_BASE)) begin
                rd = 16'(s_r.cnt[idx]);
            end else if (in_win(req.addr, `DMA_OFS_CTRL_BASE)) begin
                rd = s_r.ctrl[idx];
            end else if (req.addr == `DMA_OFS_COLL) begin
                rd = s_r.coll;
            end else if (req.addr == `DMA_OFS_IRQ_MASK) begin
                rd = s_r.mask;
            end else if (req.addr == `DMA_OFS_DONE) begin
                rd = {8'h00, s_r.done};
            end
        end
        s_nxt.rdata = rd; // Unmapped reads return zero
        s_nxt.ack = step_v;
        // Pulse with the final step so it leaves beside the last ack
        s_nxt.done_p = step_v & last_v;
        // Only unmasked collision flags drive the level; done bits do not
        s_nxt.irq = |(s_nxt.coll & s_nxt.mask);
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign RDATA_OUT = s_r.rdata;
    assign XFER_ACK_OUT = s_r.ack;
    assign BLOCK_DONE_OUT = s_r.done_p;
    assign IRQ_OUT = s_r.irq;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            DIR_TO_PER_OUT[i] = s_r.ctrl[i][`DMA_CTRL_DIR_BIT];
            PER_ADDR_OUT[i*16 +: 16] = s_r.pad[i];
        end
    end
endmodule : dma_chan_regs

// ---- test/dma_chan_regs_asserts.sv ----
// Port level checks of the channel register block
module dma_chan_regs_asserts (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] XFER_REQ_IN,
    input wire logic CPU_RAM_WR_IN,
    input wire logic CPU_PER_WR_IN,
    input wire logic [15:0] RDATA_OUT,
    input wire logic [7:0] XFER_ACK_OUT,
    input wire logic [7:0] DIR_TO_PER_OUT,
    input wire logic [127:0] PER_ADDR_OUT,
    input wire logic [7:0] BLOCK_DONE_OUT,
    input wire logic IRQ_OUT
);
    logic any_wr;
    // Only a write of some kind may raise the interrupt level
    assign any_wr = WR_IN | CPU_RAM_WR_IN | CPU_PER_WR_IN;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    chk_rd_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 16'h0000)
        else $error("read data outside the read slot");
    chk_cnt_upper: assert property (
        RD_IN && ADDR_IN[7:3] == 5'h02 |=> RDATA_OUT[15:10] == 6'h00)
        else $error("count upper bits not zero");
    chk_rd_unmapped: assert property (
        RD_IN && ADDR_IN > 8'h32 |=> RDATA_OUT == 16'h0000)
        else $error("unmapped read not zero");
    // Sync is two flops plus one for the ack; allow a cycle either side
    chk_ack_cause: assert property ((XFER_ACK_OUT & ~($past(XFER_REQ_IN, 2) |
        $past(XFER_REQ_IN, 3) | $past(XFER_REQ_IN, 4))) == 8'h00)
        else $error("ack without request");
    chk_done_ack: assert property ((BLOCK_DONE_OUT & ~XFER_ACK_OUT) == 8'h00)
        else $error("block done without last ack");
    chk_done_pulse: assert property (
        (BLOCK_DONE_OUT & $past(BLOCK_DONE_OUT)) == 8'h00)
        else $error("block done longer than one cycle");
    chk_irq_cause: assert property ($rose(IRQ_OUT) |-> $past(any_wr) ||
        $past(any_wr, 2) || $past(any_wr, 3))
        else $error("interrupt rose without a write");
    chk_dir_cause: assert property ($changed(DIR_TO_PER_OUT) |->
        $past(WR_IN) || $past(WR_IN, 2) || $past(WR_IN, 3))
        else $error("direction moved without a write");
    chk_addr_cause: assert property ($changed(PER_ADDR_OUT) |->
        $past(WR_IN) || $past(WR_IN, 2) || $past(WR_IN, 3))
        else $error("address moved without a write");
endmodule : dma_chan_regs_asserts

// ---- test/dma_far_model.sv ----
// Peripheral side that raises transfer requests and counts acks
module dma_far_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] arm_in,
    input wire logic slow_in,
    input wire logic [7:0] ack_in,
    output logic [7:0] req_out,
    output int acks_out [8]
);
    logic tick_r;
    // A slow peripheral asks only every other cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_r <= 1'b0;
            req_out <= 8'h00;
            for (int i = 0; i < 8; i++) acks_out[i] <= 0;
        end else begin
            tick_r <= ~tick_r;
            req_out <= arm_in & {8{~slow_in | tick_r}};
            for (int i = 0; i < 8; i++) acks_out[i] <= acks_out[i] + ack_in[i];
        end
    end
endmodule : dma_far_model

// ---- test/dma_chan_regs_bench.sv ----
// Register and engine tests of the channel register block
module dma_chan_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] arm = 8'h00;
    logic slow = 1'b0;
    logic cram_wr = 1'b0;
    logic cper_wr = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [15:0] rdata;
    logic [7:0] req, ack, dir, done;
    logic [127:0] per_addr;
    logic irq;
    int acks [8];
    int error_cnt = 0;
    int compares = 0;
    dma_chan_regs dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .XFER_REQ_IN(req),
        .CPU_RAM_WR_IN(cram_wr), .CPU_RAM_ADDR_IN(cpu_addr),
        .CPU_PER_WR_IN(cper_wr), .CPU_PER_ADDR_IN(cpu_addr),
        .RDATA_OUT(rdata), .XFER_ACK_OUT(ack), .DIR_TO_PER_OUT(dir),
        .PER_ADDR_OUT(per_addr), .BLOCK_DONE_OUT(done), .IRQ_OUT(irq));
    dma_far_model far (.clk_in(clk), .rst_n_in(rst_n), .arm_in(arm),
        .slow_in(slow), .ack_in(ack), .req_out(req), .acks_out(acks));
    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic chk_reg(input string n, input logic [7:0] a,
                           input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(n, e, rdata);
    endtask : chk_reg
    task automatic cmp(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // Channel stays off while its count is written, then runs one block
    task automatic run_block(input int ch, input logic [15:0] cnt,
                             input logic s);
        int n;
        int i;
        wr_reg(8'h10 + 8'(ch), cnt);
        wr_reg(8'h20 + 8'(ch), 16'h8000);
        n = acks[ch];
        slow <= s;
        arm[ch] <= 1'b1;
        // Look just after each edge so the one-cycle done pulse is settled
        for (i = 0; i < 3000 && done[ch] !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        arm[ch] <= 1'b0;
        wr_reg(8'h20 + 8'(ch), 16'h0000);
        cmp("acks", cnt + 16'h0001, 16'(acks[ch] - n));
    endtask : run_block
    task automatic print_verdict;
        $display("Compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    // Watchdog sized well beyond the longest block
    initial begin
        #200us;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            chk_reg("pad rst", 8'(i), 16'h0000);
            chk_reg("cnt rst", 8'h10 + 8'(i), 16'h0000);
            wr_reg(8'(i), {8'hC3, 8'(i)});
            wr_reg(8'h10 + 8'(i), 16'hFFFF);
            chk_reg("pad", 8'(i), {8'hC3, 8'(i)});
            chk_reg("cnt", 8'h10 + 8'(i), 16'h03FF);
        end
        chk_reg("status rst", 8'h30, 16'h0000);
        wr_reg(8'h3F, 16'hFFFF);
        chk_reg("unmapped", 8'h3F, 16'h0000);
        run_block(2, 16'h0003, 1'b0);
        run_block(5, 16'h0000, 1'b1);
        run_block(7, 16'h03FF, 1'b0);
        chk_reg("done", 8'h32, 16'h00A4);
        // Same address on both CPU paths: direction picks the flag
        wr_reg(8'h01, 16'h1234);
        wr_reg(8'h06, 16'h1234);
        wr_reg(8'h21, 16'h8000);
        wr_reg(8'h26, 16'hA000);
        arm <= 8'h42;
        cpu_addr <= 16'h1234;
        cram_wr <= 1'b1;
        cper_wr <= 1'b1;
        repeat (12) @(posedge clk);
        cram_wr <= 1'b0;
        cper_wr <= 1'b0;
        arm <= 8'h00;
        #1 cmp("dir", 16'(dir), 16'h0040);
        cmp("per addr", 16'h1234, per_addr[111:96]);
        wr_reg(8'h21, 16'h0000);
        wr_reg(8'h26, 16'h0000);
        chk_reg("status", 8'h30, 16'h4002);
        cmp("irq masked", 16'h0000, 16'(irq));
        wr_reg(8'h31, 16'h4000);
        chk_reg("mask", 8'h31, 16'h4000);
        cmp("irq", 16'h0001, 16'(irq));
        wr_reg(8'h30, 16'h4000);
        chk_reg("status clr", 8'h30, 16'h0002);
        cmp("irq clr", 16'h0000, 16'(irq));
        wr_reg(8'h30, 16'hFFFF);
        wr_reg(8'h30, 16'hFFFF);
        chk_reg("no set", 8'h30, 16'h0000);
        print_verdict();
    end
endmodule : dma_chan_regs_bench
bind dma_chan_regs dma_chan_regs_asserts chk (.CLK_IN(CLK_IN),
    .RESET_N_IN(RESET_N_IN), .ADDR_IN(ADDR_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .XFER_REQ_IN(XFER_REQ_IN), .CPU_RAM_WR_IN(CPU_RAM_WR_IN),
    .CPU_PER_WR_IN(CPU_PER_WR_IN), .RDATA_OUT(RDATA_OUT),
    .XFER_ACK_OUT(XFER_ACK_OUT), .DIR_TO_PER_OUT(DIR_TO_PER_OUT),
    .PER_ADDR_OUT(PER_ADDR_OUT), .BLOCK_DONE_OUT(BLOCK_DONE_OUT),
    .IRQ_OUT(IRQ_OUT));
